// >>> include/qpc_cfg.svh
`ifndef QPC_CFG_SVH
`define QPC_CFG_SVH

// Bus geometry
`define QPC_ADDR_W 4
`define QPC_DATA_W 16

// Register word offsets
`define QPC_OFS_CTRL 4'h0
`define QPC_OFS_FILT 4'h1
`define QPC_OFS_POS 4'h2
`define QPC_OFS_MAX 4'h3

// Control and status field positions
`define QPC_CTRL_ERR_BIT 15
`define QPC_CTRL_DIR_BIT 11
`define QPC_CTRL_MODE_HI 10
`define QPC_CTRL_MODE_LO 8
`define QPC_CTRL_PINEN_BIT 6
`define QPC_CTRL_IDXRST_BIT 2

// Filter control field positions
`define QPC_FILT_COUNT_ERROR_INT_DISABLE_BIT 8

// Reset values
`define QPC_POS_RST 16'h0000
`define QPC_MAX_RST 16'hffff
`define QPC_MODE_RST 3'h0

// Counter arithmetic constants
`define QPC_ZERO 16'h0000
`define QPC_ONE 16'h0001
`define QPC_ALL_ONES 16'hffff

`endif

// >>> include/qpc_pkg.sv
`include "qpc_cfg.svh"

package qpc_pkg;

    typedef logic [`QPC_DATA_W-1:0] qpc_word_t;
    typedef logic [`QPC_ADDR_W-1:0] qpc_addr_t;

    typedef enum logic [2:0] {
        QPC_MODE_OFF0 = 3'b000,
        QPC_MODE_OFF1 = 3'b001,
        QPC_MODE_OFF2 = 3'b010,
        QPC_MODE_OFF3 = 3'b011,
        QPC_MODE_X2_INDEX = 3'b100,
        QPC_MODE_X2_MATCH = 3'b101,
        QPC_MODE_X4_INDEX = 3'b110,
        QPC_MODE_X4_MATCH = 3'b111
    } qpc_mode_e;

endpackage

// >>> rtl/qpc_quad_decode.sv
`timescale 1ns/1ps
`include "qpc_cfg.svh"

module qpc_quad_decode
    import qpc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic phase_a_in,
    input wire logic phase_b_in,
    input wire logic index_in,
    input wire logic x4_mode,
    output logic count_pulse,
    output logic count_up,
    output logic index_pulse,
    output logic count_direction
);

    logic a_s1_q, a_s2_q, a_prev_q;
    logic b_s1_q, b_s2_q, b_prev_q;
    logic i_s1_q, i_s2_q, i_prev_q;
    logic dir_q, dir_d;
    logic a_edge, b_edge;

    always_comb begin
        a_edge = a_s2_q ^ a_prev_q;
        b_edge = b_s2_q ^ b_prev_q;
        // A edge: forward when A now differs from B; B edge: forward when equal
        count_up = a_edge ? (a_s2_q ^ b_s2_q) : ~(a_s2_q ^ b_s2_q);
        // Both phases moving at once is a lost step, not counted
        count_pulse = (a_edge & ~b_edge) | (x4_mode & b_edge & ~a_edge);
        dir_d = dir_q;
        if (a_edge ^ b_edge) begin
            dir_d = count_up;
        end
        index_pulse = i_s2_q & ~i_prev_q;
        count_direction = dir_q;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            a_s1_q <= 1'b0;
            a_s2_q <= 1'b0;
            a_prev_q <= 1'b0;
            b_s1_q <= 1'b0;
            b_s2_q <= 1'b0;
            b_prev_q <= 1'b0;
            i_s1_q <= 1'b0;
            i_s2_q <= 1'b0;
            i_prev_q <= 1'b0;
            dir_q <= 1'b0;
        end else if (ce) begin
            a_s1_q <= phase_a_in;
            a_s2_q <= a_s1_q;
            a_prev_q <= a_s2_q;
            b_s1_q <= phase_b_in;
            b_s2_q <= b_s1_q;
            b_prev_q <= b_s2_q;
            i_s1_q <= index_in;
            i_s2_q <= i_s1_q;
            i_prev_q <= i_s2_q;
            dir_q <= dir_d;
        end
    end

endmodule

// >>> rtl/qpc_top.sv
// Notes on behaviour
// - Phase A leading phase B counts forward; lagging counts reverse.
// - Sixteen-bit position counter steps by one per count pulse in derived direction.
// - Index modes: reaching max plus one or all ones sets error flag, error interrupt.
// - Error interrupt suppressed while the filter control disable bit is set.
// - After an error counting continues; up wrap gives no interrupt below max all ones, down wrap sets the error.
// - Error flag at bit 15 readable, writable; hardware only sets it.
// - Index modes with index reset enabled clear the counter on index.
// - Index reset disabled: counter keeps counting and only wraps naturally.
// - Index modes raise the position interrupt on every index pulse, not on overflow or underflow.
// - Direction driven onto its pin only while pin enable bit 6 set.
// - Mode field at bits 10 to 8 selects x2, x4 and reset variants.
// - x2 modes count on both edges of phase A; B gives direction.
// - x4 modes count on every edge of both phases.
// - Modes 101 and 111 reset the counter on max count match.
`timescale 1ns/1ps
`include "qpc_cfg.svh"

module qpc_top
    import qpc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic phase_a_in,
    input wire logic phase_b_in,
    input wire logic index_in,
    input wire qpc_addr_t reg_addr,
    input wire qpc_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output qpc_word_t reg_rdata,
    output logic dir_pin_out,
    output logic dir_pin_oe_n,
    output logic count_error_irq,
    output logic position_irq
);

    // Configuration state
    qpc_mode_e mode_q, mode_d;
    logic pin_en_q, pin_en_d;
    logic idx_rst_en_q, idx_rst_en_d;
    logic count_error_int_disable_q, count_error_int_disable_d;
    qpc_word_t max_q, max_d;

    // Counter state
    qpc_word_t pos_q, pos_d;
    logic err_q, err_d;
    logic err_irq_q, err_irq_d;
    logic pos_irq_q, pos_irq_d;

    // Bus and pin state
    qpc_word_t rdata_q, rdata_d;
    logic dir_out_q, dir_out_d;
    logic dir_oe_n_q, dir_oe_n_d;

    // Decoder outputs
    logic count_pulse;
    logic count_up;
    logic index_pulse;
    logic count_direction;

    // Counter helpers
    logic err_set;
    logic wr_ctrl, wr_filt, wr_pos, wr_max;
    qpc_word_t step;

    function automatic logic is_active(input qpc_mode_e m);
        is_active = m[2];
    endfunction

    function automatic logic is_index_mode(input qpc_mode_e m);
        is_index_mode = (m == QPC_MODE_X2_INDEX) || (m == QPC_MODE_X4_INDEX);
    endfunction

    function automatic logic is_match_mode(input qpc_mode_e m);
        is_match_mode = (m == QPC_MODE_X2_MATCH) || (m == QPC_MODE_X4_MATCH);
    endfunction

    function automatic logic is_x4_mode(input qpc_mode_e m);
        is_x4_mode = (m == QPC_MODE_X4_INDEX) || (m == QPC_MODE_X4_MATCH);
    endfunction

    function automatic qpc_word_t step_value(input qpc_word_t v, input logic up);
        step_value = up ? (v + `QPC_ONE) : (v - `QPC_ONE);
    endfunction

    qpc_quad_decode u_decode (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .phase_a_in(phase_a_in),
        .phase_b_in(phase_b_in),
        .index_in(index_in),
        .x4_mode(is_x4_mode(mode_q)),
        .count_pulse(count_pulse),
        .count_up(count_up),
        .index_pulse(index_pulse),
        .count_direction(count_direction)
    );

    // Register write decode and configuration
    always_comb begin
        wr_ctrl = reg_wr && (reg_addr == `QPC_OFS_CTRL);
        wr_filt = reg_wr && (reg_addr == `QPC_OFS_FILT);
        wr_pos = reg_wr && (reg_addr == `QPC_OFS_POS);
        wr_max = reg_wr && (reg_addr == `QPC_OFS_MAX);
        mode_d = mode_q;
        pin_en_d = pin_en_q;
        idx_rst_en_d = idx_rst_en_q;
        count_error_int_disable_d = count_error_int_disable_q;
        max_d = max_q;
        if (wr_ctrl) begin
            // Direction bit 11 is not taken from the write
            mode_d = qpc_mode_e'(reg_wdata[`QPC_CTRL_MODE_HI:`QPC_CTRL_MODE_LO]);
            pin_en_d = reg_wdata[`QPC_CTRL_PINEN_BIT];
            idx_rst_en_d = reg_wdata[`QPC_CTRL_IDXRST_BIT];
        end
        if (wr_filt) begin
            count_error_int_disable_d = reg_wdata[`QPC_FILT_COUNT_ERROR_INT_DISABLE_BIT];
        end
        if (wr_max) begin
            max_d = reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_q <= QPC_MODE_OFF0;
            pin_en_q <= 1'b0;
            idx_rst_en_q <= 1'b0;
            count_error_int_disable_q <= 1'b0;
            max_q <= `QPC_MAX_RST;
        end else if (ce) begin
            mode_q <= mode_d;
            pin_en_q <= pin_en_d;
            idx_rst_en_q <= idx_rst_en_d;
            count_error_int_disable_q <= count_error_int_disable_d;
            max_q <= max_d;
        end
    end

    // Position counter, error flag and event pulses
    always_comb begin
        pos_d = pos_q;
        err_set = 1'b0;
        err_irq_d = 1'b0;
        pos_irq_d = 1'b0;
        step = step_value(pos_q, count_up);
        if (!is_active(mode_q)) begin
            pos_d = pos_q;
        end else if (is_index_mode(mode_q)) begin
            if (count_pulse) begin
                // Free 16-bit wrap; the wrap down to all ones is itself a count error
                pos_d = step;
                if ((count_up && (step == (max_q + `QPC_ONE))) ||
                    (!count_up && (step == `QPC_ALL_ONES))) begin
                    err_set = 1'b1;
                    err_irq_d = ~count_error_int_disable_q;
                end
            end
            if (index_pulse) begin
                pos_irq_d = 1'b1;
                if (idx_rst_en_q) begin
                    pos_d = `QPC_ZERO;
                end
            end
        end else if (is_match_mode(mode_q)) begin
            // Index pulse has no effect in match modes
            if (count_pulse) begin
                if (count_up && (pos_q == max_q)) begin
                    pos_d = `QPC_ZERO;
                    pos_irq_d = 1'b1;
                end else if (!count_up && (pos_q == `QPC_ZERO)) begin
                    pos_d = max_q;
                    pos_irq_d = 1'b1;
                end else begin
                    pos_d = step;
                end
            end
        end
        // Software load beats a same-cycle count step
        if (wr_pos) begin
            pos_d = reg_wdata;
        end
        // Hardware set wins over a software clear in the same cycle
        if (err_set) begin
            err_d = 1'b1;
        end else if (wr_ctrl) begin
            err_d = reg_wdata[`QPC_CTRL_ERR_BIT];
        end else begin
            err_d = err_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pos_q <= `QPC_POS_RST;
            err_q <= 1'b0;
            err_irq_q <= 1'b0;
            pos_irq_q <= 1'b0;
        end else if (ce) begin
            pos_q <= pos_d;
            err_q <= err_d;
            err_irq_q <= err_irq_d;
            pos_irq_q <= pos_irq_d;
        end
    end

    // Read data and direction pin
    always_comb begin
        rdata_d = `QPC_ZERO;
        if (reg_rd) begin
            unique case (reg_addr)
                `QPC_OFS_CTRL: begin
                    rdata_d[`QPC_CTRL_ERR_BIT] = err_q;
                    rdata_d[`QPC_CTRL_DIR_BIT] = count_direction;
                    rdata_d[`QPC_CTRL_MODE_HI:`QPC_CTRL_MODE_LO] = mode_q;
                    rdata_d[`QPC_CTRL_PINEN_BIT] = pin_en_q;
                    rdata_d[`QPC_CTRL_IDXRST_BIT] = idx_rst_en_q;
                end
                `QPC_OFS_FILT: begin
                    rdata_d[`QPC_FILT_COUNT_ERROR_INT_DISABLE_BIT] = count_error_int_disable_q;
                end
                `QPC_OFS_POS: begin
                    rdata_d = pos_q;
                end
                `QPC_OFS_MAX: begin
                    rdata_d = max_q;
                end
                default: begin
                    // Unmapped offsets read as zero
                    rdata_d = `QPC_ZERO;
                end
            endcase
        end
        dir_out_d = pin_en_q & count_direction;
        dir_oe_n_d = ~pin_en_q;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= `QPC_ZERO;
            dir_out_q <= 1'b0;
            dir_oe_n_q <= 1'b1;
        end else if (ce) begin
            rdata_q <= rdata_d;
            dir_out_q <= dir_out_d;
            dir_oe_n_q <= dir_oe_n_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign dir_pin_out = dir_out_q;
    assign dir_pin_oe_n = dir_oe_n_q;
    assign count_error_irq = err_irq_q;
    assign position_irq = pos_irq_q;

endmodule

// >>> sim/qpc_enc_model.sv
`timescale 1ns/1ps
module qpc_enc_model (
    input wire logic ref_clk,
    output logic phase_a,
    output logic phase_b,
    output logic index
);
    logic [1:0] ph = 2'h0;
    initial index = 1'b0;
    // Gray walk 00,10,11,01: forward means A leads B
    assign phase_a = ph == 2'h1 || ph == 2'h2;
    assign phase_b = ph[1];
    task automatic step(input bit fwd);
        @(posedge ref_clk);
        ph <= fwd ? ph + 2'h1 : ph - 2'h1;
        repeat (6) @(posedge ref_clk);
    endtask
    // Caller parks both phases low first
    task automatic pulse();
        @(posedge ref_clk);
        index <= 1'b1;
        repeat (3) @(posedge ref_clk);
        index <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
endmodule

// >>> sim/qpc_top_props.sv
`timescale 1ns/1ps
module qpc_top_props
    import qpc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic phase_a_in,
    input wire logic phase_b_in,
    input wire logic index_in,
    input wire qpc_addr_t reg_addr,
    input wire qpc_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire qpc_word_t reg_rdata,
    input wire logic dir_pin_out,
    input wire logic dir_pin_oe_n,
    input wire logic count_error_irq,
    input wire logic position_irq
);
    logic [3:0] quiet_q;
    logic [3:0] quiet_d;
    logic [2:0] pins_q;
    // Cycles since any pin moved, saturating
    always_comb begin
        quiet_d = quiet_q + {3'h0, quiet_q != 4'hf};
        if ({phase_a_in, phase_b_in, index_in} != pins_q) quiet_d = 4'h0;
    end
    always_ff @(posedge ref_clk) begin
        pins_q <= {phase_a_in, phase_b_in, index_in};
        quiet_q <= rst ? 4'hf : quiet_d;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read");
    AST_PIN_OFF: assert property (dir_pin_oe_n |-> !dir_pin_out)
        else $error("direction pin driven while disabled");
    AST_OE_STABLE: assert property (!$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(dir_pin_oe_n))
        else $error("pin enable moved without a write");
    AST_EIRQ_CAUSE: assert property (count_error_irq |-> quiet_q <= 4'h6)
        else $error("error irq without encoder activity");
    AST_PIRQ_CAUSE: assert property (position_irq |-> quiet_q <= 4'h6)
        else $error("position irq without encoder activity");
    AST_EIRQ_PULSE: assert property (count_error_irq |=> !count_error_irq)
        else $error("error irq longer than one cycle");
    AST_PIRQ_PULSE: assert property (position_irq |=> !position_irq)
        else $error("position irq longer than one cycle");
    AST_MODE_RW: assert property (reg_wr && reg_addr == 4'h0 ##1 reg_rd && reg_addr == 4'h0
        |=> (reg_rdata & 16'h0744) == ($past(reg_wdata, 2) & 16'h0744))
        else $error("control fields not stored");
    AST_MAX_RW: assert property (reg_wr && reg_addr == 4'h3 ##1 reg_rd && reg_addr == 4'h3
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("max count not stored");
endmodule
bind qpc_top qpc_top_props u_props (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .phase_a_in(phase_a_in), .phase_b_in(phase_b_in), .index_in(index_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dir_pin_out(dir_pin_out), .dir_pin_oe_n(dir_pin_oe_n),
    .count_error_irq(count_error_irq), .position_irq(position_irq));

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_top;
    import qpc_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    qpc_addr_t reg_addr = 4'h0;
    qpc_word_t reg_wdata = 16'h0000;
    qpc_word_t reg_rdata, v, x_pos, mx;
    logic pa, pb, idx, dout, oen, eirq, pirq;
    int n_mismatch = 0, checks_done = 0, seed = 5473, n_p = 0, n_e = 0, x_p, x_e;
    logic [2:0] m;
    bit dir, count_error_int_disable, pen, irs, err;
    qpc_enc_model enc (.ref_clk(ref_clk), .phase_a(pa), .phase_b(pb), .index(idx));
    qpc_top dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .phase_a_in(pa), .phase_b_in(pb),
        .index_in(idx), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dir_pin_out(dout), .dir_pin_oe_n(oen),
        .count_error_irq(eirq), .position_irq(pirq));
    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        n_p += (pirq === 1'b1);
        n_e += (eirq === 1'b1);
    end
    function automatic qpc_word_t ctl(bit e, bit d);
        return {e, 3'h0, d, m, 1'b0, pen, 3'h0, irs, 2'h0};
    endfunction
    task automatic wr(input qpc_addr_t a, input qpc_word_t d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        // Idle edge so a following write never re-raises the strobe in the same step
        @(posedge ref_clk);
    endtask
    // Write then read back with no gap between the strobes
    task automatic wrd(input qpc_addr_t a, input qpc_word_t d, output qpc_word_t q);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        rd(a, q);
    endtask
    task automatic rd(input qpc_addr_t a, output qpc_word_t d);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
        @(posedge ref_clk);
    endtask
    // Expected counter step; x2 counts only moves that toggle A
    task automatic mstep(input bit f);
        qpc_word_t n;
        if (m[2] && (m[1] || enc.ph[0] != f)) begin
            n = f ? x_pos + 16'h0001 : x_pos - 16'h0001;
            if (m[0] && (f ? x_pos == mx : x_pos == 16'h0000)) begin
                n = f ? 16'h0000 : mx;
                x_p++;
            end else if (!m[0] && n == (f ? mx + 16'h0001 : 16'hffff)) begin
                err = 1'b1;
                x_e += !count_error_int_disable;
            end
            x_pos = n;
        end
        dir = f;
        enc.step(f);
    endtask
    task automatic summarize();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #1_000_000;
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(4'h0, v); `CHK(v, 16'h0000)
        rd(4'h3, v); `CHK(v, 16'hffff)
        rd(4'h9, v); `CHK(v, 16'h0000)
        for (int i = 0; i < 5; i++) begin
            m = (i == 0) ? 3'h0 : 3'h3 + 3'(i);
            mx = {14'h0000, 2'($random(seed))} + 16'h0004;
            count_error_int_disable = m == 3'h6;
            pen = m[0];
            irs = m == 3'h4;
            err = 1'b0;
            x_pos = 16'h0000;
            x_p = n_p;
            x_e = n_e;
            wrd(4'h3, mx, v); `CHK(v, mx)
            wr(4'h1, {7'h00, count_error_int_disable, 8'h00});
            wr(4'h2, 16'h0000);
            wr(4'h0, ctl(1'b0, 1'b0));
            // Inactive mode walks backwards only, so direction stays known
            for (int k = 0; k < 24; k++) mstep(m[2] & 1'($random(seed)));
            while (enc.ph != 2'h0) mstep(m[2]);
            enc.pulse();
            x_p += m[2] & !m[0];
            if (irs) x_pos = 16'h0000;
            rd(4'h2, v); `CHK(v, x_pos)
            `CHK(n_p, x_p)
            `CHK(n_e, x_e)
            rd(4'h0, v); `CHK(v, ctl(err, dir))
            wrd(4'h0, ctl(1'b0, !dir), v); `CHK(v, ctl(1'b0, dir))
            `CHK(dout, pen & dir)
            `CHK(oen, !pen)
        end
        // Clock enable low must drop a write
        ce <= 1'b0;
        wr(4'h3, ~mx);
        ce <= 1'b1;
        rd(4'h3, v); `CHK(v, mx)
        summarize();
    end
endmodule
